/* File: shared/tpf_params.svh */
/*
 * Offsets, field positions, reset values and widths for the test pattern
 * and frame clock block and its controller.
 * Assumes inclusion by bare name from the package and the modules.
 */
`ifndef TPF_PARAMS_SVH
`define TPF_PARAMS_SVH

// Device register offsets, one byte each
`define TPF_OFS_PAT_LOW 8'h14
`define TPF_OFS_PAT_MID 8'h15
`define TPF_OFS_PAT_SEL 8'h16
`define TPF_OFS_RCB_CTL 8'h18
`define TPF_OFS_FRM_CTL 8'h19
`define TPF_OFS_AUX_CTL 8'h1F
`define TPF_REG_RESET 8'h00

// Field positions
`define TPF_SEL_B_HI 7
`define TPF_SEL_B_LO 5
`define TPF_SEL_A_HI 4
`define TPF_SEL_A_LO 2
`define TPF_PAT_TOP_HI 1
`define TPF_RCB_ON_BIT 4
`define TPF_AUX_ON_BIT 6
`define TPF_FRM_ORIGIN_BIT 7
`define TPF_FRM_HALVE_BIT 4
`define TPF_FRM_PIN_BIT 1
`define TPF_FRM_STRETCH_BIT 0

// Pattern select codes
`define TPF_SEL_NORMAL 3'h0
`define TPF_SEL_RAMP 3'h2
`define TPF_SEL_CONST 3'h3

// Enable values written during mode apply
`define TPF_RCB_ON_VAL 8'h10
`define TPF_AUX_ON_VAL 8'h40

// Native resolution and buffer depth
`define TPF_NATIVE_W 18
`define TPF_BUF_DEPTH 2

// Controller APB offsets
`define TPF_APB_CMD 12'h000
`define TPF_APB_MODE 12'h004
`define TPF_APB_STATUS 12'h008

// Controller command and mode fields
`define TPF_CMD_READ_BIT 16
`define TPF_CMD_APPLY_BIT 17
`define TPF_WIRES_TWO 2'h0
`define TPF_WIRES_ONE 2'h1
`define TPF_WIRES_HALF 2'h2
`define TPF_MODE_CPLX_BIT 2
`define TPF_APPLY_LAST 2'h2

`endif

/* File: shared/tpf_pkg.sv */
/*
 * Types shared by the pattern device end and its controller.
 * Assumes tpf_params.svh on the include path.
 */
`include "tpf_params.svh"

package tpf_pkg;

   typedef enum logic [2:0] {
      TPF_H_IDLE = 3'h1,
      TPF_H_ISSUE = 3'h2,
      TPF_H_WAIT = 3'h4
   } tpf_host_st_t;

   typedef struct packed {
      logic [7:0] pat_low;
      logic [7:0] pat_mid;
      logic [7:0] pat_sel;
      logic [7:0] rcb_ctl;
      logic [7:0] frm_ctl;
      logic aux_on;
      logic [7:0] rdata;
      logic ack;
      logic [`TPF_NATIVE_W-1:0] ramp_a;
      logic [`TPF_NATIVE_W-1:0] ramp_b;
      logic halve_t;
      logic pulse_dly;
      logic frame;
      logic pin;
   } tpf_dev_state_t;

   typedef struct packed {
      tpf_host_st_t st;
      logic [1:0] step;
      logic apply;
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic [2:0] mode;
   } tpf_host_state_t;

endpackage : tpf_pkg

/* File: shared/tpf_link_if.sv */
/*
 * Link between the pattern device and the capturing controller:
 * byte-wide register port plus the sample stream and shared frame pin.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`include "tpf_params.svh"

interface tpf_link_if;
   // Register port
   logic req;
   logic we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   // Sample stream
   logic dvalid;
   logic dready;
   logic [`TPF_NATIVE_W-1:0] da;
   logic [`TPF_NATIVE_W-1:0] db;
   logic pin;

   modport dev (
      input req, we, addr, wdata, dready,
      output ack, rdata, dvalid, da, db, pin
   );

   modport host (
      output req, we, addr, wdata, dready,
      input ack, rdata, dvalid, da, db, pin
   );
endinterface : tpf_link_if

/* File: logic/tpf_buf.sv */
/*
 * Small ring buffer with valid/ready on both sides.
 * Assumes one clock; storage is flip-flops.
 */
`timescale 1ns/1ps

module tpf_buf #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("tpf_buf: DEPTH must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } tpf_buf_state_t;

   tpf_buf_state_t q, d;
   logic push, pop;

   assign in_ready_o = (q.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (q.cnt != '0);
   assign out_data_o = q.mem[q.rp];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wp] = in_data_i;
         d.wp = q.wp + AW'(1);
      end
      if (pop) begin
         d.rp = q.rp + AW'(1);
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : tpf_buf

/* File: logic/tpf_dev_end.sv */
/*
 * Device end: pattern registers, per-channel test pattern insertion,
 * frame clock shaping and the shared frame pin, with a two-entry
 * buffer ahead of the sample stream.
 * Assumes conversion data and frame pulses come from logic on ref_clk_i
 * and the register port is driven by the controller on the same clock.
 */
// The implementer's own choice: the APB slave port.
// Overview of operation
// - Constant mode outputs 18-bit word, MSB aligned.
// - Ramp mode uses custom word as step.
// - Channel B select bits 7-5 choose output.
// - Channel A select bits 4-2 choose output.
// - Patterns inserted pre-mapper, native MSB-justified.
// - Pattern identical under every output format.
// - Return clock buffer needs both enables.
// - Origin 0 takes frame from converter core.
// - Origin 1 takes frame from down-converter.
// - Halve only for 2-wire bypass.
// - Pin bit selects data or frame clock.
// - Stretch widens frame over both words.
// - Controller combines frame settings per mode.
`timescale 1ns/1ps
`include "tpf_params.svh"

module tpf_dev_end #(
   parameter int NATIVE_W = `TPF_NATIVE_W,
   parameter int BUF_DEPTH = `TPF_BUF_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Conversion samples
   input wire logic sample_valid_i,
   output logic sample_ready_o,
   input wire logic [NATIVE_W-1:0] conv_a_i,
   input wire logic [NATIVE_W-1:0] conv_b_i,
   // Frame pulses
   input wire logic core_frame_i,
   input wire logic downconv_frame_i,
   // Clock buffer power
   output logic return_clock_buffer_on_o,
   // Link
   tpf_link_if.dev link
);
   // The select register holds exactly the top two word bits
   if (NATIVE_W != `TPF_NATIVE_W) begin : g_bad_width
      $error("tpf_dev_end: pattern fields are fixed at 18 bits");
   end
   if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("tpf_dev_end: BUF_DEPTH must be a power of two, at least 2");
   end

   ////////////////////////////////////////////////////////////////////
   // Pattern selection

   // Unused select codes fall back to live data, so a bad write
   // never freezes the stream.
   function automatic logic [NATIVE_W-1:0] pick(
      input logic [2:0] sel,
      input logic [NATIVE_W-1:0] conv,
      input logic [NATIVE_W-1:0] ramp,
      input logic [NATIVE_W-1:0] word
   );
      logic [NATIVE_W-1:0] r;
      r = conv;
      case (sel)
         `TPF_SEL_RAMP: r = ramp;
         `TPF_SEL_CONST: r = word;
         default: r = conv;
      endcase
      return r;
   endfunction : pick

   // Read-back byte for an offset; unmapped offsets read as zero
   function automatic logic [7:0] read_back(
      input logic [7:0] addr,
      input tpf_pkg::tpf_dev_state_t s
   );
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         `TPF_OFS_PAT_LOW: v = s.pat_low;
         `TPF_OFS_PAT_MID: v = s.pat_mid;
         `TPF_OFS_PAT_SEL: v = s.pat_sel;
         `TPF_OFS_RCB_CTL: v = s.rcb_ctl;
         `TPF_OFS_FRM_CTL: v = s.frm_ctl;
         // Only the enable bit of the aux register is kept
         `TPF_OFS_AUX_CTL: v = {1'b0, s.aux_on, 6'h00};
         default: v = 8'h00;
      endcase
      return v;
   endfunction : read_back

   tpf_pkg::tpf_dev_state_t q, d;
   logic [NATIVE_W-1:0] word;
   logic [2:0] sel_a;
   logic [2:0] sel_b;
   logic [NATIVE_W-1:0] out_a;
   logic [NATIVE_W-1:0] out_b;
   logic buf_ready;
   logic push;
   logic src_pulse;
   logic pass_pulse;
   localparam int BUF_W = 2 * NATIVE_W;
   logic [BUF_W-1:0] buf_out;

   // Top two bits sit in the select register
   assign word = {q.pat_sel[`TPF_PAT_TOP_HI:0], q.pat_mid, q.pat_low};
   assign sel_b = q.pat_sel[`TPF_SEL_B_HI:`TPF_SEL_B_LO];
   assign sel_a = q.pat_sel[`TPF_SEL_A_HI:`TPF_SEL_A_LO];
   assign out_a = pick(sel_a, conv_a_i, q.ramp_a, word);
   assign out_b = pick(sel_b, conv_b_i, q.ramp_b, word);
   assign push = sample_valid_i && buf_ready;
   assign sample_ready_o = buf_ready;

   ////////////////////////////////////////////////////////////////////
   // Frame clock shaping

   // Both frame inputs are one-cycle pulses on ref_clk_i
   assign src_pulse = q.frm_ctl[`TPF_FRM_ORIGIN_BIT] ? downconv_frame_i
                                                     : core_frame_i;
   // Halve passes every second pulse
   assign pass_pulse = src_pulse && (!q.frm_ctl[`TPF_FRM_HALVE_BIT] || q.halve_t);

   ////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      d = q;
      d.ack = 1'b0;
      // One access per req; ack and read-back follow on the next edge
      if (link.req) begin
         d.ack = 1'b1;
         if (link.we) begin
            case (link.addr)
               `TPF_OFS_PAT_LOW: d.pat_low = link.wdata;
               `TPF_OFS_PAT_MID: d.pat_mid = link.wdata;
               `TPF_OFS_PAT_SEL: d.pat_sel = link.wdata;
               `TPF_OFS_RCB_CTL: d.rcb_ctl = link.wdata;
               `TPF_OFS_FRM_CTL: d.frm_ctl = link.wdata;
               `TPF_OFS_AUX_CTL: d.aux_on = link.wdata[`TPF_AUX_ON_BIT];
               default: d.ack = 1'b1;
            endcase
            // Writes clear the read-back byte
            d.rdata = 8'h00;
         end else begin
            d.rdata = read_back(link.addr, q);
         end
      end

      // Step once per accepted sample, natural wrap at 18 bits
      if (push) begin
         d.ramp_a = q.ramp_a + word;
         d.ramp_b = q.ramp_b + word;
      end
      // Ramp restarts from zero while its channel is not ramping
      if (sel_a != `TPF_SEL_RAMP) begin
         d.ramp_a = '0;
      end
      if (sel_b != `TPF_SEL_RAMP) begin
         d.ramp_b = '0;
      end

      if (src_pulse) begin
         d.halve_t = !q.halve_t;
      end
      d.pulse_dly = pass_pulse;
      // Stretch holds the frame one more cycle to cover channel B
      d.frame = pass_pulse || (q.frm_ctl[`TPF_FRM_STRETCH_BIT] && q.pulse_dly);
      d.pin = q.frm_ctl[`TPF_FRM_PIN_BIT] ? d.frame : buf_out[0];
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Output stream

   tpf_buf #(
      .WIDTH(BUF_W),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(sample_valid_i),
      .in_ready_o(buf_ready),
      .in_data_i({out_a, out_b}),
      .out_valid_o(link.dvalid),
      .out_ready_i(link.dready),
      .out_data_o(buf_out)
   );

   // Channel A rides in the upper half of each entry
   assign link.da = buf_out[BUF_W-1:NATIVE_W];
   assign link.db = buf_out[NATIVE_W-1:0];
   // Pin, ack and read-back come straight from flops
   assign link.pin = q.pin;
   assign link.ack = q.ack;
   assign link.rdata = q.rdata;
   assign return_clock_buffer_on_o = q.rcb_ctl[`TPF_RCB_ON_BIT] && q.aux_on;
endmodule : tpf_dev_end

/* File: logic/tpf_host_end.sv */
/*
 * Controller end: APB slave that issues register accesses to the
 * pattern device and applies frame settings per interface mode,
 * and passes the captured sample stream to its user.
 * Assumes APB and the device share ref_clk_i.
 */
`timescale 1ns/1ps
`include "tpf_params.svh"

module tpf_host_end (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Captured stream
   output logic cap_valid_o,
   input wire logic cap_ready_i,
   output logic [`TPF_NATIVE_W-1:0] cap_a_o,
   output logic [`TPF_NATIVE_W-1:0] cap_b_o,
   output logic cap_pin_o,
   // Link
   tpf_link_if.host link
);
   // Frame control byte for a mode: origin, halve, pin, stretch
   function automatic logic [7:0] frame_for(input logic [2:0] mode);
      logic [7:0] v;
      logic cplx;
      v = 8'h00;
      cplx = mode[`TPF_MODE_CPLX_BIT];
      v[`TPF_FRM_PIN_BIT] = 1'b1;
      v[`TPF_FRM_ORIGIN_BIT] = cplx && mode[1:0] != `TPF_WIRES_HALF;
      v[`TPF_FRM_HALVE_BIT] = !cplx && mode[1:0] == `TPF_WIRES_TWO;
      v[`TPF_FRM_STRETCH_BIT] = cplx && mode[1:0] == `TPF_WIRES_HALF;
      return v;
   endfunction : frame_for

   tpf_pkg::tpf_host_state_t q, d;
   logic wr_acc;
   logic busy;
   logic mapped;

   assign wr_acc = psel && penable && pwrite;
   assign busy = (q.st != tpf_pkg::TPF_H_IDLE);
   assign mapped = (paddr == `TPF_APB_CMD) || (paddr == `TPF_APB_MODE) || (paddr == `TPF_APB_STATUS);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always_comb begin
      case (paddr)
         `TPF_APB_MODE: prdata = {29'h0, q.mode};
         `TPF_APB_STATUS: prdata = {23'h0, q.rdata, busy};
         default: prdata = 32'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Command sequencer

   // Commands written while busy are dropped; software polls busy.
   always_comb begin
      d = q;
      case (q.st)
         tpf_pkg::TPF_H_IDLE: begin
            if (wr_acc && paddr == `TPF_APB_MODE) begin
               d.mode = pwdata[2:0];
            end
            if (wr_acc && paddr == `TPF_APB_CMD) begin
               d.st = tpf_pkg::TPF_H_ISSUE;
               d.step = 2'h0;
               d.apply = pwdata[`TPF_CMD_APPLY_BIT];
               d.we = !pwdata[`TPF_CMD_READ_BIT] || pwdata[`TPF_CMD_APPLY_BIT];
               d.addr = pwdata[`TPF_CMD_APPLY_BIT] ? `TPF_OFS_FRM_CTL : pwdata[15:8];
               d.wdata = pwdata[`TPF_CMD_APPLY_BIT] ? frame_for(q.mode) : pwdata[7:0];
            end
         end
         tpf_pkg::TPF_H_ISSUE: begin
            d.st = tpf_pkg::TPF_H_WAIT;
         end
         tpf_pkg::TPF_H_WAIT: begin
            if (link.ack) begin
               d.rdata = link.rdata;
               d.st = tpf_pkg::TPF_H_IDLE;
               // Both return clock enables must be set
               if (q.apply && q.step != `TPF_APPLY_LAST) begin
                  d.st = tpf_pkg::TPF_H_ISSUE;
                  d.step = q.step + 2'h1;
                  d.addr = (q.step == 2'h0) ? `TPF_OFS_RCB_CTL : `TPF_OFS_AUX_CTL;
                  d.wdata = (q.step == 2'h0) ? `TPF_RCB_ON_VAL : `TPF_AUX_ON_VAL;
               end
            end
         end
         default: d.st = tpf_pkg::TPF_H_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         q <= '{st: tpf_pkg::TPF_H_IDLE, default: '0};
      end else begin
         q <= d;
      end
   end

   assign link.req = (q.st == tpf_pkg::TPF_H_ISSUE);
   assign link.we = q.we;
   assign link.addr = q.addr;
   assign link.wdata = q.wdata;
   assign link.dready = cap_ready_i;
   assign cap_valid_o = link.dvalid;
   assign cap_a_o = link.da;
   assign cap_b_o = link.db;
   assign cap_pin_o = link.pin;
endmodule : tpf_host_end

/* File: testbench/tpf_link_assertions.sv */
/* Link checker: register port and stream rules.
   Assumes one clock, instanced beside tpf_link_if. */
`timescale 1ns/1ps
`include "tpf_params.svh"
module tpf_link_assertions (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Link
   input wire logic req,
   input wire logic we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata,
   input wire logic dvalid,
   input wire logic dready,
   input wire logic [`TPF_NATIVE_W-1:0] da,
   input wire logic [`TPF_NATIVE_W-1:0] db,
   input wire logic pin
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   wire logic fw = req && we && addr == `TPF_OFS_FRM_CTL;
   ////////////////////////////////////////////////////////////
   a_req_gets_ack: assert property (req |=> ack && !req)
      else $error("no ack");
   a_ack_has_req: assert property (ack |-> $past(req))
      else $error("stray ack");
   a_rdata_holds: assert property (!req && !ack |=> $stable(rdata))
      else $error("rdata moved");
   a_stream_holds: assert property (dvalid && !dready |=> dvalid && $stable(da) && $stable(db))
      else $error("stream lost");
   a_halve_bypass: assert property (fw && wdata[4] |-> !wdata[7] && !wdata[0])
      else $error("bad halve");
   a_stretch_core: assert property (fw && wdata[0] |-> !wdata[7] && !wdata[4])
      else $error("bad stretch");
   a_origin_down: assert property (fw && wdata[7] |-> !wdata[0] && !wdata[4])
      else $error("bad origin");
   a_frame_pin_on: assert property (fw |-> wdata[1] && wdata[6:5] == 2'h0 && wdata[3:2] == 2'h0)
      else $error("bad frame bits");
   a_both_enables: assert property (req && we && addr == `TPF_OFS_RCB_CTL |-> wdata == 8'h10
      ##[2:4] (req && we && addr == `TPF_OFS_AUX_CTL && wdata == 8'h40))
      else $error("enable pair");
   c_stretch: cover property (fw && wdata[0]);
   c_stall: cover property (dvalid && !dready ##1 dvalid && !dready);
   c_access: cover property (req ##1 ack);
endmodule : tpf_link_assertions

/* File: testbench/test_pattern_frame_clock_cfg_tb.sv */
/* Bench: controller and device ends joined, driven over APB and
   the sample port. Assumes the shared package files are compiled first. */
`timescale 1ns/1ps
`include "tpf_params.svh"
module test_pattern_frame_clock_cfg_tb;
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cap_valid_o;
   logic cap_ready_i = 1'b0;
   logic [17:0] cap_a_o;
   logic [17:0] cap_b_o;
   logic cap_pin_o;
   logic sample_valid_i = 1'b0;
   logic sample_ready_o;
   logic [17:0] conv_a_i = 18'h0;
   logic [17:0] conv_b_i = 18'h0;
   logic core_frame_i = 1'b0;
   logic downconv_frame_i = 1'b0;
   logic rcb_on;
   logic [7:0] rd;
   int n_fail = 0;
   int checks = 0;
   always #5 ref_clk_i = ~ref_clk_i;
   tpf_link_if link ();
   tpf_dev_end i_tpf_dev_end (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .conv_a_i(conv_a_i),
      .conv_b_i(conv_b_i), .core_frame_i(core_frame_i), .downconv_frame_i(downconv_frame_i),
      .return_clock_buffer_on_o(rcb_on), .link(link));
   tpf_host_end i_tpf_host_end (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cap_valid_o(cap_valid_o), .cap_ready_i(cap_ready_i),
      .cap_a_o(cap_a_o), .cap_b_o(cap_b_o), .cap_pin_o(cap_pin_o), .link(link));
   tpf_link_assertions i_tpf_link_assertions (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
      .rdata(link.rdata), .dvalid(link.dvalid), .dready(link.dready), .da(link.da),
      .db(link.db), .pin(link.pin));
   ////////////////////////////////////////////////////////////
   task automatic results();
      if (n_fail == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic stuck();
      n_fail++;
      $display("BAD %0t wait expired", $time);
      results();
   endtask : stuck
   // Bounded wait for a level sampled at a rising edge
   task automatic until_high(ref logic s);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (s !== 1'b1 && n < 40);
      if (s !== 1'b1) stuck();
   endtask : until_high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge ref_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      penable <= 1'b1;
      until_high(pready);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Controller command, then poll busy; commands sent while busy are dropped
   task automatic cmd(input logic [31:0] w);
      logic [31:0] r;
      logic e;
      int n;
      apb(1'b1, `TPF_APB_CMD, w, r, e);
      n = 0;
      do begin
         apb(1'b0, `TPF_APB_STATUS, 32'h0, r, e);
         n++;
      end while (r[0] !== 1'b0 && n < 20);
      if (r[0] !== 1'b0) stuck();
      rd = r[8:1];
   endtask : cmd
   task automatic dev(input logic rdb, input logic [7:0] a, input logic [7:0] d);
      cmd({15'h0, rdb, a, d});
   endtask : dev
   task automatic send(input logic [17:0] a, input logic [17:0] b);
      @(posedge ref_clk_i);
      sample_valid_i <= 1'b1;
      conv_a_i <= a;
      conv_b_i <= b;
      until_high(sample_ready_o);
      sample_valid_i <= 1'b0;
   endtask : send
   task automatic recv(input logic [17:0] ea, input logic [17:0] eb);
      @(posedge ref_clk_i);
      cap_ready_i <= 1'b1;
      until_high(cap_valid_o);
      chk({14'h0, cap_a_o}, {14'h0, ea});
      chk({14'h0, cap_b_o}, {14'h0, eb});
      cap_ready_i <= 1'b0;
   endtask : recv
   task automatic pulses(input bit dn, output int cnt);
      cnt = 0;
      for (int i = 0; i < 24; i++) begin
         @(posedge ref_clk_i);
         if (cap_pin_o === 1'b1) cnt++;
         core_frame_i <= !dn && i % 5 == 0 && i < 20;
         downconv_frame_i <= dn && i % 5 == 0 && i < 20;
      end
   endtask : pulses
   ////////////////////////////////////////////////////////////
   task automatic regs_reset();
      logic [7:0] ofs[5] = '{8'h14, 8'h15, 8'h16, 8'h18, 8'h19};
      for (int k = 0; k < 5; k++) begin
         dev(1'b1, ofs[k], 8'h00);
         chk({24'h0, rd}, 32'h0);
      end
      chk({31'h0, rcb_on}, 32'h0);
      dev(1'b0, `TPF_OFS_AUX_CTL, 8'h40);
      chk({31'h0, rcb_on}, 32'h0);
   endtask : regs_reset
   task automatic pat_const();
      dev(1'b0, `TPF_OFS_PAT_LOW, 8'hA5);
      dev(1'b0, `TPF_OFS_PAT_MID, 8'h3C);
      dev(1'b0, `TPF_OFS_PAT_SEL, 8'h6E);
      dev(1'b1, `TPF_OFS_PAT_SEL, 8'h00);
      chk({24'h0, rd}, 32'h6E);
      send(18'h00001, 18'h3FFFE);
      recv(18'h23CA5, 18'h23CA5);
   endtask : pat_const
   // B ramps by the top step, A on an unused code; receiver stalls
   task automatic pat_ramp();
      dev(1'b0, `TPF_OFS_PAT_LOW, 8'h00);
      dev(1'b0, `TPF_OFS_PAT_MID, 8'h00);
      dev(1'b0, `TPF_OFS_PAT_SEL, 8'h46);
      send(18'h11111, 18'h0);
      send(18'h22222, 18'h0);
      @(posedge ref_clk_i);
      chk({31'h0, sample_ready_o}, 32'h0);
      recv(18'h11111, 18'h00000);
      recv(18'h22222, 18'h20000);
      send(18'h33333, 18'h0);
      recv(18'h33333, 18'h00000);
      // A ramps by the finest step, B back on live data
      dev(1'b0, `TPF_OFS_PAT_LOW, 8'h01);
      dev(1'b0, `TPF_OFS_PAT_SEL, 8'h08);
      send(18'h3FFFF, 18'h15555);
      send(18'h3FFFF, 18'h2AAAA);
      recv(18'h00000, 18'h15555);
      recv(18'h00001, 18'h2AAAA);
   endtask : pat_ramp
   task automatic frames();
      logic [2:0] md[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
      logic [7:0] fc[6] = '{8'h12, 8'h02, 8'h02, 8'h82, 8'h82, 8'h03};
      int nc[6] = '{2, 4, 4, 0, 0, 8};
      int nd[6] = '{0, 0, 0, 4, 4, 0};
      logic [31:0] r;
      logic e;
      int cnt;
      for (int k = 0; k < 6; k++) begin
         apb(1'b1, `TPF_APB_MODE, {29'h0, md[k]}, r, e);
         dev(1'b0, 8'h00, 8'h00);
         cmd(32'h0002_0000);
         dev(1'b1, `TPF_OFS_FRM_CTL, 8'h00);
         chk({24'h0, rd}, {24'h0, fc[k]});
         chk({31'h0, rcb_on}, 32'h1);
         pulses(1'b0, cnt);
         chk(cnt, nc[k]);
         pulses(1'b1, cnt);
         chk(cnt, nd[k]);
      end
   endtask : frames
   task automatic apb_map();
      logic [31:0] r;
      logic e;
      apb(1'b0, `TPF_APB_MODE, 32'h0, r, e);
      chk({r[2:0], e}, 4'hC);
      apb(1'b0, 12'h00C, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
   endtask : apb_map
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      regs_reset();
      pat_const();
      pat_ramp();
      frames();
      apb_map();
      results();
   end
endmodule : test_pattern_frame_clock_cfg_tb
